// *** testbench/tcim_src.sv ***
// model of the sensors and encoders that drive the measurement pins
// assumes the bench calls its tasks; pins idle high (meas) and low (phases)
`timescale 1ns/1ps
`default_nettype none
module tcim_src (
  // clock
  input wire logic clk_i,
  // pins
  output logic meas_o,
  output logic [1:0] ph1_o,
  output logic [1:0] ph2_o
);
  initial begin
    meas_o = 1'b1;
    ph1_o = 2'b00;
    ph2_o = 2'b00;
  end

  // lo or hi below 5 clocks would break the input rate limit, so clamp
  task automatic pulses(input int n, input int lo, input int hi);
    repeat (n) begin
      @(posedge clk_i);
      meas_o <= 1'b0;
      repeat ((lo < 5) ? 5 : lo) @(posedge clk_i);
      meas_o <= 1'b1;
      repeat ((hi < 5) ? 4 : hi - 1) @(posedge clk_i);
    end
  endtask

  // bit 0 is phase a, bit 1 phase b; one change held 6 clocks
  task automatic step(input logic sel, input logic [1:0] v);
    @(posedge clk_i);
    if (sel) begin
      ph2_o <= v;
    end else begin
      ph1_o <= v;
    end
    repeat (5) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** testbench/test_timer_counter_input_modes.sv ***
// self-checking bench: register port, total, quadrature, period, on-time
// and pulse count; assumes tcim_src on the pins and a short gate window
`timescale 1ns/1ps
`default_nettype none
module test_timer_counter_input_modes;
  localparam int GATE = 200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, meas;
  logic [1:0] bresp, rresp, ph1, ph2;
  logic [31:0] rdata;
  logic [31:0] rng = 32'h0001_85C0;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;

  tcim_src src (.clk_i(clk), .meas_o(meas), .ph1_o(ph1), .ph2_o(ph2));

  tcim_top #(.GATE_CYC(GATE)) dut (
    .SYS_CLK_I(clk), .RST_I(rst), .MEAS_IN_I(meas),
    .TC1_PHASE_A_PIN_I(ph1[0]), .TC1_PHASE_B_PIN_I(ph1[1]),
    .TC2_PHASE_A_PIN_I(ph2[0]), .TC2_PHASE_B_PIN_I(ph2[1]),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready),
    .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready)
  );

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic mode(input logic [2:0] m, input logic inv, input logic sel);
    logic [1:0] r;
    wr(tcim_pkg::CTRL_OFS, {25'h0, sel, 1'b0, inv, 1'b0, m}, r);
    repeat (6) @(posedge clk);
  endtask

  // a count may land one tick either side of the ideal figure
  function automatic logic [31:0] near(input logic [31:0] v, input int e);
    return 32'(int'(v) >= e - 1 && int'(v) <= e + 1);
  endfunction

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    logic [31:0] d;
    logic [31:0] t;
    logic [1:0] r;
    logic [1:0] v;
    int n;
    int e;
    int lo;
    logic [5:0] b;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(tcim_pkg::THRESH_OFS, d, r);
    check(32'(d[15:0]), 32'(tcim_pkg::THRESH_RESET));
    check(32'(r), 32'h0);
    rd(tcim_pkg::MAXPER_OFS, d, r);
    check(32'(d[15:0]), 32'(tcim_pkg::MAXPER_RESET));
    rd(tcim_pkg::PRESC_OFS, d, r);
    check(32'(d[7:0]), 32'(tcim_pkg::PRESC_RESET));
    rd(8'h20, d, r);
    check(32'(r), 32'h2);
    wr(8'h05, 32'h1, r);
    check(32'(r), 32'h2);
    wr(tcim_pkg::PRESC_OFS, 32'h0, r);
    $display("registers done");
    for (int i = 0; i < 2; i++) begin
      mode(tcim_pkg::M_TOTAL, i[0], 1'b0);
      rd(tcim_pkg::RESULT_OFS, d, r);
      n = 1 + int'(xs() % 20);
      src.pulses(n, 5 + int'(xs() % 4), 5 + int'(xs() % 4));
      repeat (4) @(posedge clk);
      rd(tcim_pkg::RESULT_OFS, d, r);
      check(d, 32'(n));
      rd(tcim_pkg::RESULT_OFS, d, r);
      check(d, 32'h0);
    end
    $display("total count done");
    for (int s = 0; s < 2; s++) begin
      mode(tcim_pkg::M_QUAD, 1'b0, s[0]);
      rd(tcim_pkg::RESULT_OFS, d, r);
      e = 0;
      repeat (40) begin
        t = xs();
        v = (s[0] ? ph2 : ph1) ^ (t[0] ? 2'b10 : 2'b01);
        src.step(s[0], v);
        if (t[0]) e += (v[1] == v[0]) ? 1 : -1;
      end
      rd(tcim_pkg::RESULT_OFS, d, r);
      check(32'(d[15:0]), 32'(e[15:0]));
      rd(tcim_pkg::RESULT_OFS, d, r);
      check(32'(d[15:0]), 32'h0);
    end
    $display("quadrature done");
    for (int i = 0; i < 4; i++) begin
      mode((i < 2) ? tcim_pkg::M_PERIOD : tcim_pkg::M_ONTIME, i[0], 1'b0);
      lo = i[0] ? 14 : 6;
      src.pulses(4, lo, 24 - lo);
      rd(tcim_pkg::STATUS_OFS, d, r);
      check(32'(d[0]), 32'h1);
      rd(tcim_pkg::RESULT_OFS, d, r);
      check(near(d, (i < 2) ? 24 : (i[0] ? lo : 24 - lo)), 32'h1);
      rd(tcim_pkg::STATUS_OFS, d, r);
      check(32'(d[0]), 32'h0);
    end
    $display("period and on-time done");
    mode(tcim_pkg::M_PULSE, 1'b0, 1'b0);
    src.pulses(50, 5, 5);
    rd(tcim_pkg::STATUS_OFS, d, r);
    check(32'(d[0]), 32'h1);
    rd(tcim_pkg::RESULT_OFS, d, r);
    check(near(d, GATE / 10), 32'h1);
    $display("pulse count done");
    // infrared: 10-clock cycles decode as one, 30-clock cycles as zero
    wr(tcim_pkg::THRESH_OFS, 32'h0000_0014, r);
    wr(tcim_pkg::MAXPER_OFS, 32'h0000_0028, r);
    b = 6'(xs());
    wr(tcim_pkg::CTRL_OFS, 32'h0000_0021, r);
    for (int j = 0; j < 6; j++) begin
      src.pulses(1, b[j] ? 5 : 15, b[j] ? 5 : 15);
    end
    // the last falling edge closes the sixth bit, then the line idles
    src.pulses(1, 5, 5);
    repeat (60) @(posedge clk);
    rd(tcim_pkg::STATUS_OFS, d, r);
    check(32'(d[2:1]), 32'h2);
    rd(tcim_pkg::IRCNT_OFS, d, r);
    check(d, 32'h6);
    rd(tcim_pkg::IRBITS_OFS, d, r);
    check(32'(d[5:0]), 32'(b));
    $display("infrared done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** verilog/tcim_bitmem.sv ***
// small bit buffer for decoded infrared bits, registered read
// assumes one write and one read port on the same clock
`timescale 1ns/1ps
`default_nettype none
module tcim_bitmem #(
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic wbit_i,
  output logic [DEPTH-1:0] rdata_o
);
  logic [DEPTH-1:0] mem_q;

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wbit_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem_q;
  end
endmodule
`default_nettype wire

// *** verilog/tcim_pkg.sv ***
// package for the timer/counter input-measurement block
// assumes a 40 MHz system clock and an AXI4-Lite register port
package tcim_pkg;

  // --------------------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] THRESH_OFS = 8'h04;
  localparam logic [7:0] MAXPER_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] RESULT_OFS = 8'h10;
  localparam logic [7:0] IRBITS_OFS = 8'h14;
  localparam logic [7:0] IRCNT_OFS = 8'h18;
  localparam logic [7:0] PRESC_OFS = 8'h1C;

  // --------------------------------------------------------------------------
  // control fields
  // --------------------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_INV_BIT = 4;
  localparam int CTRL_START_BIT = 5;
  localparam int CTRL_SEL_BIT = 6;
  localparam int STAT_NEW_BIT = 0;
  localparam int STAT_IRBUSY_BIT = 1;
  localparam int STAT_IRDONE_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] MAXPER_RESET = 16'hFFFF;
  localparam logic [15:0] THRESH_RESET = 16'h0100;
  localparam logic [7:0] PRESC_RESET = 8'h03;

  // --------------------------------------------------------------------------
  // modes and timing
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    M_OFF, M_IR, M_ONTIME, M_PERIOD, M_PULSE, M_QUAD, M_TOTAL
  } tcim_mode_t;

  localparam real CLK_MHZ = 40.0;
  localparam real GATE_S = 0.8388608;
  localparam int GATE_CYCLES = int'(GATE_S * CLK_MHZ * 1.0E6);
  localparam logic [15:0] QUAD_MAX = 16'h3FFF;
  localparam logic [15:0] QUAD_MIN = 16'hC000;
  localparam int IR_DEPTH = 32;

endpackage

// *** verilog/tcim_sync.sv ***
// two-flop synchroniser for a group of pin inputs
// assumes pins are asynchronous to SYS_CLK_I
`timescale 1ns/1ps
`default_nettype none
module tcim_sync #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** verilog/tcim_top.sv ***
// timer/counter input measurement: infrared, on-time, period, pulse count,
// quadrature and total count, reached over AXI4-Lite
// assumes pins are asynchronous; bus master on SYS_CLK_I
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [R1] infrared bit is one if its cycle is shorter than threshold, else zero
// [R2] infrared bits are timed between falling edges, rising when inverted
// [R3] infrared bits go to a buffer; capture ends max-period after last bit
// [R4] on-time counts prescaled ticks only while input is asserted
// [R5] on-time asserted level is high, low when inverted
// [R6] period mode captures and restarts the free counter at each active edge
// [R7] period active edge falling by default, rising inverted; same result
// [R8] pulse count counts active edges up to 65535 in 0.8388608 s window
// [R9] at each window end the count is saved and cleared, forever
// [R10] pulse count advances once per active input edge, falling by default
// [R11] quadrature counts up when b falls with a low or rises with a high
// [R12] quadrature read returns net signed sum since last read, then clears; a b edge in the read cycle is lost
// [R13] quadrature result is 16-bit two's complement, saturating at 16K
// [R14] source keeps transition rate at most a quarter of the input clock
// [R15] phase pins: tc1 uses pins six and seven, tc2 pins four and five
// [R16] total count counts one polarity only, falling default, rising inverted
// [R17] total count read returns edges since last read, then clears
// [R18] first measurement after reset is discarded
// [R19] completion loads the result register; later ones overwrite unread ones
// [R20] new-result flag set on load, cleared on read
// [R21] inputs are synchronised before edges or levels are detected
module tcim_top #(
  parameter int GATE_CYC = tcim_pkg::GATE_CYCLES,
  parameter int IR_DEPTH = tcim_pkg::IR_DEPTH
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // measurement pins
  input wire logic MEAS_IN_I,
  input wire logic TC1_PHASE_A_PIN_I,
  input wire logic TC1_PHASE_B_PIN_I,
  input wire logic TC2_PHASE_A_PIN_I,
  input wire logic TC2_PHASE_B_PIN_I,
  // axi4-lite write
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // axi4-lite read
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I
);
  initial begin
    if (GATE_CYC < 2 || IR_DEPTH < 2 || IR_DEPTH > 32) begin
      $error("tcim_top: unsupported parameter");
    end
  end

  localparam int IAW = $clog2(IR_DEPTH);

  // --------------------------------------------------------------------------
  // registers and decode
  // --------------------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [15:0] thresh_q, maxper_q, result_q, cnt_q;
  logic [7:0] presc_q;
  logic new_q, first_q, ir_busy_q, ir_done_q;
  logic aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wr_go, rd_go, rd_result;
  tcim_pkg::tcim_mode_t mode;

  function automatic logic is_reg(input logic [7:0] a);
    is_reg = (a[1:0] == 2'h0) && (a <= tcim_pkg::PRESC_OFS);
  endfunction

  assign mode = tcim_pkg::tcim_mode_t'(ctrl_q[tcim_pkg::CTRL_MODE_LSB +: 3]);
  assign wr_go = aw_q && w_q && !BVALID_O;
  assign rd_go = ARVALID_I && ARREADY_O;
  assign rd_result = rd_go && ARADDR_I == tcim_pkg::RESULT_OFS;

  // write channel: take address and data in any order, answer after both
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      AWREADY_O <= 1'b1;
      WREADY_O <= 1'b1;
      BVALID_O <= 1'b0;
      BRESP_O <= 2'h0;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_q <= 1'b1;
        awaddr_q <= AWADDR_I;
        AWREADY_O <= 1'b0;
      end
      if (WVALID_I && WREADY_O) begin
        w_q <= 1'b1;
        wdata_q <= WDATA_I;
        WREADY_O <= 1'b0;
      end
      if (wr_go) begin
        BVALID_O <= 1'b1;
        BRESP_O <= is_reg(awaddr_q) ? 2'h0 : 2'h2;
        aw_q <= 1'b0;
        w_q <= 1'b0;
      end
      if (BVALID_O && BREADY_I) begin
        BVALID_O <= 1'b0;
        AWREADY_O <= 1'b1;
        WREADY_O <= 1'b1;
      end
    end
  end

  // software registers; start is a self-clearing bit
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ctrl_q <= tcim_pkg::CTRL_RESET;
      thresh_q <= tcim_pkg::THRESH_RESET;
      maxper_q <= tcim_pkg::MAXPER_RESET;
      presc_q <= tcim_pkg::PRESC_RESET;
    end else begin
      ctrl_q[tcim_pkg::CTRL_START_BIT] <= 1'b0;
      if (wr_go && WSTRB_I[0]) begin
        unique case (awaddr_q)
          tcim_pkg::CTRL_OFS: ctrl_q <= {24'h000000, wdata_q[7:0]};
          tcim_pkg::THRESH_OFS: thresh_q <= wdata_q[15:0];
          tcim_pkg::MAXPER_OFS: maxper_q <= wdata_q[15:0];
          tcim_pkg::PRESC_OFS: presc_q <= wdata_q[7:0];
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // input path
  // --------------------------------------------------------------------------
  logic [4:0] pins_s;
  logic [2:0] hist_q;
  logic qa_prev_q, qb_prev_q;
  logic inv, sig, act_edge, level_on, qa, qb, qb_edge, qup;

  tcim_sync #(.W(5)) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .d_i({MEAS_IN_I, TC2_PHASE_B_PIN_I, TC2_PHASE_A_PIN_I,
          TC1_PHASE_B_PIN_I, TC1_PHASE_A_PIN_I}), // R21
    .q_o(pins_s)
  );

  assign inv = ctrl_q[tcim_pkg::CTRL_INV_BIT];
  assign sig = pins_s[4];
  // falling edge normally, rising when inverted
  assign act_edge = inv ? (sig && !hist_q[0]) : (!sig && hist_q[0]); // R2 R7 R10 R16
  assign level_on = sig ^ inv; // R5
  assign qa = ctrl_q[tcim_pkg::CTRL_SEL_BIT] ? pins_s[2] : pins_s[0]; // R15
  assign qb = ctrl_q[tcim_pkg::CTRL_SEL_BIT] ? pins_s[3] : pins_s[1]; // R15
  assign qb_edge = qb != qb_prev_q;
  assign qup = (!qb && !qa) || (qb && qa); // R11

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      hist_q <= 3'h0;
      qa_prev_q <= 1'b0;
      qb_prev_q <= 1'b0;
    end else begin
      hist_q <= {hist_q[1:0], sig};
      qa_prev_q <= qa;
      qb_prev_q <= qb;
    end
  end

  // prescaled tick
  logic [7:0] pdiv_q;
  logic tick;
  assign tick = pdiv_q == presc_q;
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || tick) begin
      pdiv_q <= 8'h00;
    end else begin
      pdiv_q <= pdiv_q + 8'h01;
    end
  end

  // pulse-count gate window, independent of prescaler
  logic [31:0] gate_q;
  logic gate_end;
  assign gate_end = gate_q == 32'(GATE_CYC - 1); // R8
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || gate_end || mode != tcim_pkg::M_PULSE) begin
      gate_q <= 32'h0000_0000;
    end else begin
      gate_q <= gate_q + 32'h0000_0001;
    end
  end

  // --------------------------------------------------------------------------
  // measurement counter and result
  // --------------------------------------------------------------------------
  logic done, on_end, ir_edge, ir_timeout;
  logic [15:0] done_val;
  assign on_end = mode == tcim_pkg::M_ONTIME && !level_on && (hist_q[0] ^ inv);
  assign ir_edge = mode == tcim_pkg::M_IR && ir_busy_q && act_edge;

  always_comb begin
    done = 1'b0;
    done_val = cnt_q;
    unique case (mode)
      tcim_pkg::M_ONTIME: done = on_end;
      tcim_pkg::M_PERIOD: done = act_edge; // R6
      tcim_pkg::M_PULSE: done = gate_end; // R9
      default: done = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      cnt_q <= 16'h0000;
    end else begin
      unique case (mode)
        tcim_pkg::M_ONTIME: begin
          if (on_end) begin
            cnt_q <= 16'h0000; // R19
          end else if (level_on && tick && cnt_q != 16'hFFFF) begin
            cnt_q <= cnt_q + 16'h0001; // R4
          end
        end
        tcim_pkg::M_PERIOD, tcim_pkg::M_IR: begin
          if (act_edge) begin
            cnt_q <= 16'h0000; // R6
          end else if (tick && cnt_q != 16'hFFFF) begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        tcim_pkg::M_PULSE: begin
          if (gate_end) begin
            cnt_q <= 16'h0000; // R9
          end else if (act_edge && cnt_q != 16'hFFFF) begin
            cnt_q <= cnt_q + 16'h0001; // R8 R10
          end
        end
        tcim_pkg::M_TOTAL: begin
          if (rd_result) begin
            cnt_q <= act_edge ? 16'h0001 : 16'h0000; // R17
          end else if (act_edge) begin
            cnt_q <= cnt_q + 16'h0001; // R16
          end
        end
        tcim_pkg::M_QUAD: begin
          if (rd_result) begin
            cnt_q <= 16'h0000; // R12
          end else if (qb_edge && qup && cnt_q != tcim_pkg::QUAD_MAX) begin
            cnt_q <= cnt_q + 16'h0001; // R13
          end else if (qb_edge && !qup && cnt_q != tcim_pkg::QUAD_MIN) begin
            cnt_q <= cnt_q - 16'h0001; // R13
          end
        end
        default: cnt_q <= 16'h0000;
      endcase
    end
  end

  // result and new flag; a load in the read cycle wins over the clear
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      result_q <= 16'h0000;
      new_q <= 1'b0;
      first_q <= 1'b1;
    end else if (done) begin
      first_q <= 1'b0;
      if (!first_q) begin // R18
        result_q <= done_val; // R19
        new_q <= 1'b1; // R20
      end
    end else if (rd_result) begin
      new_q <= 1'b0; // R20
    end
  end

  // --------------------------------------------------------------------------
  // infrared capture
  // --------------------------------------------------------------------------
  logic [IAW:0] ir_n_q;
  logic [15:0] ir_idle_q;
  logic ir_armed_q, ir_we;
  logic [IR_DEPTH-1:0] ir_bits;
  assign ir_we = ir_edge && ir_armed_q && ir_n_q < (IAW+1)'(IR_DEPTH);
  assign ir_timeout = ir_busy_q && tick && ir_idle_q >= maxper_q;

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ir_busy_q <= 1'b0;
      ir_done_q <= 1'b0;
      ir_armed_q <= 1'b0;
      ir_n_q <= '0;
      ir_idle_q <= 16'h0000;
    end else if (ctrl_q[tcim_pkg::CTRL_START_BIT] && mode == tcim_pkg::M_IR) begin
      ir_busy_q <= 1'b1;
      ir_done_q <= 1'b0;
      ir_armed_q <= 1'b0;
      ir_n_q <= '0;
      ir_idle_q <= 16'h0000;
    end else if (ir_edge) begin
      ir_armed_q <= 1'b1;
      ir_idle_q <= 16'h0000;
      if (ir_we) begin
        ir_n_q <= ir_n_q + 1'b1;
      end
    end else if (ir_timeout) begin
      ir_busy_q <= 1'b0; // R3
      ir_done_q <= 1'b1;
    end else if (ir_busy_q && tick) begin
      ir_idle_q <= ir_idle_q + 16'h0001;
    end
  end

  tcim_bitmem #(.DEPTH(IR_DEPTH)) u_bits (
    .clk_i(SYS_CLK_I),
    .we_i(ir_we), // R3
    .waddr_i(ir_n_q[IAW-1:0]),
    .wbit_i(cnt_q < thresh_q), // R1
    .rdata_o(ir_bits)
  );

  // --------------------------------------------------------------------------
  // read channel
  // --------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h0000_0000;
      RRESP_O <= 2'h0;
    end else if (rd_go) begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b1;
      RRESP_O <= is_reg(ARADDR_I) ? 2'h0 : 2'h2;
      unique case (ARADDR_I)
        tcim_pkg::CTRL_OFS: RDATA_O <= ctrl_q;
        tcim_pkg::THRESH_OFS: RDATA_O <= {16'h0000, thresh_q};
        tcim_pkg::MAXPER_OFS: RDATA_O <= {16'h0000, maxper_q};
        tcim_pkg::STATUS_OFS: RDATA_O <= {29'h0, ir_done_q, ir_busy_q, new_q};
        tcim_pkg::RESULT_OFS: begin
          if (mode == tcim_pkg::M_QUAD || mode == tcim_pkg::M_TOTAL) begin
            RDATA_O <= {16'h0000, cnt_q}; // R12 R17
          end else begin
            RDATA_O <= {16'h0000, result_q};
          end
        end
        tcim_pkg::IRBITS_OFS: RDATA_O <= 32'(ir_bits);
        tcim_pkg::IRCNT_OFS: RDATA_O <= 32'(ir_n_q);
        tcim_pkg::PRESC_OFS: RDATA_O <= {24'h000000, presc_q};
        default: RDATA_O <= 32'h0000_0000;
      endcase
    end else if (RVALID_O && RREADY_I) begin
      RVALID_O <= 1'b0;
      ARREADY_O <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  sequence s_gate_end;
    mode == tcim_pkg::M_PULSE && gate_end;
  endsequence

  pulse_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R9
    s_gate_end |=> cnt_q == 16'h0000) else $error("pulse count not cleared");
  quad_sat_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R13
    mode == tcim_pkg::M_QUAD |-> ($signed(cnt_q) <= 16'sh3FFF &&
    $signed(cnt_q) >= -16'sh4000)) else $error("quadrature out of range");
  quad_up_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R11
    mode == tcim_pkg::M_QUAD && qb_edge && qup && !rd_result && cnt_q != 16'h3FFF
    |=> cnt_q == $past(cnt_q) + 16'h0001) else $error("quadrature up missed");
  quad_clr_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R12
    mode == tcim_pkg::M_QUAD && rd_result |=> cnt_q == 16'h0000)
    else $error("quadrature not cleared");
  total_read_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R17
    mode == tcim_pkg::M_TOTAL && rd_result |=> RDATA_O == {16'h0000, $past(cnt_q)})
    else $error("total count read wrong");
  ontime_gate_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R4
    mode == tcim_pkg::M_ONTIME && !level_on && $stable(mode) |=> $stable(cnt_q) ||
    cnt_q == 16'h0000) else $error("on-time counted while idle");
  first_drop_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R18
    done && first_q |=> !new_q) else $error("first result reported");
  new_set_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R20
    done && !first_q |=> new_q && result_q == $past(done_val))
    else $error("result not loaded");
  period_cap_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R6
    mode == tcim_pkg::M_PERIOD && act_edge |=> cnt_q == 16'h0000)
    else $error("period not restarted");
  ir_end_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R3
    ir_timeout && !ctrl_q[tcim_pkg::CTRL_START_BIT] && !ir_edge |=> !ir_busy_q && ir_done_q)
    else $error("infrared capture did not end");
endmodule
`default_nettype wire
